/* rtl/sbg_pkg.sv */
// Shared constants for the scan bridge port gating block
package sbg_pkg;

    // Port counts and widths
    localparam int NUM_PORTS = 3;
    localparam int NUM_PASS  = 2;
    localparam int SLOT_W    = 7;

    // Stages in each pin synchroniser
    localparam int SYNC_STAGES = 2;

    // Width of the synchronised pin bundle
    localparam int PIN_W = 6 + NUM_PASS + NUM_PORTS + SLOT_W;

    // Bit positions inside the synchronised pin bundle
    localparam int PIN_TCK     = 0;
    localparam int PIN_TMS     = 1;
    localparam int PIN_TDI     = 2;
    localparam int PIN_TRST_N  = 3;
    localparam int PIN_OE_N    = 4;
    localparam int PIN_PASS_B  = 5;
    localparam int PIN_PASS_L  = 6;
    localparam int PIN_TDI_L   = PIN_PASS_L + NUM_PASS;
    localparam int PIN_SLOT    = PIN_TDI_L + NUM_PORTS;

    // Reset values; pins idle high as their pull-ups would leave them
    localparam logic [PIN_W-1:0] PIN_RST = {PIN_W{1'b1}};
    localparam logic             PAD_RST  = 1'b1;
    localparam logic             TMS_RST  = 1'b1;
    localparam logic             PASS_IDLE = 1'b1;
    localparam logic             TCK_RST  = 1'b1;

    // Timing: fastest test clock the bench uses, and the system clock
    localparam int TCK_PERIOD_NS = 400;
    localparam int CLK_PERIOD_NS = 50;
    // Least clock cycles per test clock half period (rounded down)
    localparam int TCK_HALF_CYC = (TCK_PERIOD_NS / 2) / CLK_PERIOD_NS;

endpackage : sbg_pkg

/* rtl/sbg_sync.sv */
// Two-flop synchroniser for a bundle of pins
`timescale 1ns/10ps
`default_nettype none

module sbg_sync #(
    parameter int                    W       = 1,
    parameter logic [W-1:0]          RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         sys_rst,
    // Pin side
    input  wire logic [W-1:0] async_in,
    // Clock domain side
    output var  logic [W-1:0] sync_out
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    // First stage is read only by the second
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    // Register both stages
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;

endmodule : sbg_sync

`default_nettype wire

/* rtl/sbg_port_gate.sv */
// Backplane to local scan port gating, pass-through and chain routing
//
// Behaviour
// - Backplane hiz notify high while its output floats
// - Backplane pass input to single selected port
// - Single selected port pass input to backplane
// - Pass-through exists only on ports zero, one
// - Output enable high floats every local port
// - Local test clocks copy backplane test clock
// - Local test resets gate backplane test reset
// - Test reset low initialises internal logic but the pin synchroniser, clock edge detector and reset gate
// - Backplane test clock paces scan input capture, pad sampling and internal registers
// - Backplane mode select drives own and local TAPs
// - Address comes from seven static slot inputs
// - Scan data enters only on backplane input
// - Backplane output returns own and ring data
// - One activity enable output per local port
// - Local hiz notify high while port floats
// - Pad bit samples ring data on falling clock
// - Parked port holds its mode select constant
// - Chain: input, own register, rings, pad, output
`timescale 1ns/10ps
`default_nettype none

module sbg_port_gate #(
    parameter int NPORT = sbg_pkg::NUM_PORTS,
    parameter int NPASS = sbg_pkg::NUM_PASS,
    parameter int SLOTW = sbg_pkg::SLOT_W
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             sys_rst,
    // Backplane pins
    input  wire logic             tck_b,
    input  wire logic             tms_b,
    input  wire logic             tdi_b,
    input  wire logic             trst_n_b,
    output var  logic             tdo_b,
    output var  logic             tdo_b_oe,
    output var  logic             hiz_notify_b,
    input  wire logic             pass_in_b,
    output var  logic             pass_out_b,
    input  wire logic [SLOTW-1:0] slot_id,
    input  wire logic             lsp_oe_n,
    // Local scan port pins
    output var  logic [NPORT-1:0] local_tck,
    output var  logic [NPORT-1:0] local_tms,
    output var  logic [NPORT-1:0] local_tdo,
    input  wire logic [NPORT-1:0] local_tdi,
    output var  logic [NPORT-1:0] local_trst_n,
    output var  logic [NPORT-1:0] local_scan_port_oe,
    output var  logic [NPORT-1:0] hiz_notify,
    output var  logic [NPORT-1:0] port_activity_enable,
    input  wire logic [NPASS-1:0] local_pass_in,
    output var  logic [NPASS-1:0] local_pass_out,
    // Ties to the selection and park controllers
    input  wire logic [NPORT-1:0] port_selected,
    input  wire logic [NPORT-1:0] port_unparked,
    input  wire logic             own_tdo,
    input  wire logic             tdo_b_drive,
    // Toward the internal registers
    output var  logic             tck_rise,
    output var  logic             tck_fall,
    output var  logic             scan_in,
    output var  logic             scan_mode,
    output var  logic [SLOTW-1:0] slot_addr,
    output var  logic             logic_clear
);

    localparam int PW = 6 + NPASS + NPORT + SLOTW;
    localparam int P_PASS_L = 6;
    localparam int P_TDI_L  = P_PASS_L + NPASS;
    localparam int P_SLOT   = P_TDI_L + NPORT;

    // Synchronised copies of every pin that crosses into clk
    logic [PW-1:0] pin_raw;
    logic [PW-1:0] pin_s;
    logic          tck_s;
    logic          tms_s;
    logic          tdi_s;
    logic          trst_n_s;
    logic          oe_n_s;
    logic          pass_b_s;
    logic [NPASS-1:0] pass_l_s;
    logic [NPORT-1:0] tdi_l_s;
    logic [SLOTW-1:0] slot_s;

    assign pin_raw = {slot_id, local_tdi, local_pass_in, pass_in_b,
                      lsp_oe_n, trst_n_b, tdi_b, tms_b, tck_b};

    sbg_sync #(
        .W       (PW),
        .RST_VAL ({PW{1'b1}})
    ) u_pin_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in (pin_raw),
        .sync_out (pin_s)
    );

    // Unpack the synchronised bundle
    assign tck_s    = pin_s[sbg_pkg::PIN_TCK];
    assign tms_s    = pin_s[sbg_pkg::PIN_TMS];
    assign tdi_s    = pin_s[sbg_pkg::PIN_TDI];
    assign trst_n_s = pin_s[sbg_pkg::PIN_TRST_N];
    assign oe_n_s   = pin_s[sbg_pkg::PIN_OE_N];
    assign pass_b_s = pin_s[sbg_pkg::PIN_PASS_B];
    assign pass_l_s = pin_s[P_PASS_L +: NPASS];
    assign tdi_l_s  = pin_s[P_TDI_L +: NPORT];
    assign slot_s   = pin_s[P_SLOT +: SLOTW];

    // Internal clear; test reset acts on every flop below except trst_gate_reg and tck_prev_reg
    logic clear;
    assign clear = sys_rst | ~trst_n_s;
    assign logic_clear = clear;

    // Local resets bypass the clock so a low level reaches rings at once
    logic trst_gate_reg;
    logic trst_gate_next;
    always_comb begin
        trst_gate_next = 1'b1;
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trst_gate_reg <= 1'b0;
        end else begin
            trst_gate_reg <= trst_gate_next;
        end
    end
    assign local_trst_n = {NPORT{trst_n_b & trst_gate_reg}};

    // Test clock edge detection; scan input capture, pad sampling and the internal registers wait on these edges
    logic tck_prev_reg;
    logic tck_prev_next;
    logic scan_in_reg;
    logic scan_in_next;
    logic rise_w;
    logic fall_w;

    assign rise_w = tck_s & ~tck_prev_reg;
    assign fall_w = ~tck_s & tck_prev_reg;

    always_comb begin
        tck_prev_next = tck_s;
        scan_in_next  = scan_in_reg;
        if (rise_w) begin
            scan_in_next = tdi_s;
        end
    end
    always_ff @(posedge clk) begin
        if (clear) begin
            // Follow the pin through clear so its release shows no false edge
            tck_prev_reg <= tck_prev_next;
            scan_in_reg  <= 1'b1;
        end else begin
            tck_prev_reg <= tck_prev_next;
            scan_in_reg  <= scan_in_next;
        end
    end
    assign tck_rise  = rise_w;
    assign tck_fall  = fall_w;
    assign scan_in   = scan_in_reg;
    assign scan_mode = tms_s;

    // Slot address, caught continuously from the static straps
    logic [SLOTW-1:0] slot_reg;
    logic [SLOTW-1:0] slot_next;
    always_comb begin
        slot_next = slot_s;
    end
    always_ff @(posedge clk) begin
        if (clear) begin
            slot_reg <= '0;
        end else begin
            slot_reg <= slot_next;
        end
    end
    assign slot_addr = slot_reg;

    // Serial chain: own register, then each inserted ring via its pad
    logic [NPORT:0]   chain;
    logic [NPORT-1:0] pad_reg;
    logic [NPORT-1:0] pad_next;
    logic [NPORT-1:0] hold_reg;
    logic [NPORT-1:0] hold_next;
    logic [NPORT-1:0] tms_reg;
    logic [NPORT-1:0] tms_next;
    logic [NPORT-1:0] tdo_reg;
    logic [NPORT-1:0] tdo_next;
    logic [NPORT-1:0] act_reg;
    logic [NPORT-1:0] act_next;

    assign chain[0] = own_tdo;

    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_port
            // Next values for one local port
            always_comb begin
                pad_next[gi]  = pad_reg[gi];
                hold_next[gi] = hold_reg[gi];
                if (fall_w && port_unparked[gi]) begin
                    pad_next[gi] = tdi_l_s[gi];
                end
                if (port_unparked[gi]) begin
                    hold_next[gi] = tms_s;
                end
                // Parked ports replay the level held at park time
                tms_next[gi] = port_unparked[gi] ? tms_s
                                                 : hold_reg[gi];
                tdo_next[gi] = chain[gi];
                act_next[gi] = port_unparked[gi]
                             & port_selected[gi];
            end

            // Ring output feeds the next stage only when inserted
            assign chain[gi+1] = port_unparked[gi] ? pad_reg[gi]
                                                   : chain[gi];

            always_ff @(posedge clk) begin
                if (clear) begin
                    pad_reg[gi]  <= sbg_pkg::PAD_RST;
                    hold_reg[gi] <= sbg_pkg::TMS_RST;
                    tms_reg[gi]  <= sbg_pkg::TMS_RST;
                    tdo_reg[gi]  <= 1'b1;
                    act_reg[gi]  <= 1'b0;
                end else begin
                    pad_reg[gi]  <= pad_next[gi];
                    hold_reg[gi] <= hold_next[gi];
                    tms_reg[gi]  <= tms_next[gi];
                    tdo_reg[gi]  <= tdo_next[gi];
                    act_reg[gi]  <= act_next[gi];
                end
            end
        end
    endgenerate

    assign local_tms            = tms_reg;
    assign local_tdo            = tdo_reg;
    assign port_activity_enable = act_reg;

    // Local port drive and clock fan-out
    logic             tck_l_reg;
    logic             tck_l_next;
    logic             oe_l_reg;
    logic             oe_l_next;
    always_comb begin
        tck_l_next = tck_s;
        oe_l_next  = ~oe_n_s;
    end
    always_ff @(posedge clk) begin
        if (clear) begin
            tck_l_reg <= sbg_pkg::TCK_RST;
            oe_l_reg  <= 1'b0;
        end else begin
            tck_l_reg <= tck_l_next;
            oe_l_reg  <= oe_l_next;
        end
    end
    assign local_tck          = {NPORT{tck_l_reg}};
    assign local_scan_port_oe = {NPORT{oe_l_reg}};
    assign hiz_notify         = {NPORT{~oe_l_reg}};

    // Backplane data return; drive window comes from the TAP
    logic tdo_b_reg;
    logic tdo_b_next;
    logic tdo_oe_reg;
    logic tdo_oe_next;
    always_comb begin
        tdo_b_next  = chain[NPORT];
        tdo_oe_next = tdo_b_drive;
    end
    always_ff @(posedge clk) begin
        if (clear) begin
            tdo_b_reg  <= 1'b1;
            tdo_oe_reg <= 1'b0;
        end else begin
            tdo_b_reg  <= tdo_b_next;
            tdo_oe_reg <= tdo_oe_next;
        end
    end
    assign tdo_b        = tdo_b_reg;
    assign tdo_b_oe     = tdo_oe_reg;
    assign hiz_notify_b = ~tdo_oe_reg;

    // Pass-through works only with exactly one port selected
    logic             single_sel;
    logic [NPASS-1:0] pass_l_reg;
    logic [NPASS-1:0] pass_l_next;
    logic             pass_b_reg;
    logic             pass_b_next;

    assign single_sel = (port_selected != '0)
                      && ((port_selected & (port_selected - NPORT'(1))) == '0);

    always_comb begin
        pass_l_next = {NPASS{sbg_pkg::PASS_IDLE}};
        pass_b_next = sbg_pkg::PASS_IDLE;
        for (int k = 0; k < NPASS; k++) begin
            // Port two has no pass pins, so it never appears here
            if (single_sel && port_selected[k]) begin
                pass_l_next[k] = pass_b_s;
                pass_b_next    = pass_l_s[k];
            end
        end
    end
    always_ff @(posedge clk) begin
        if (clear) begin
            pass_l_reg <= {NPASS{sbg_pkg::PASS_IDLE}};
            pass_b_reg <= sbg_pkg::PASS_IDLE;
        end else begin
            pass_l_reg <= pass_l_next;
            pass_b_reg <= pass_b_next;
        end
    end
    assign local_pass_out = pass_l_reg;
    assign pass_out_b     = pass_b_reg;

endmodule : sbg_port_gate

`default_nettype wire

/* test/sbg_port_gate_props.sv */
// Concurrent checks on the pins of the port gating block
`timescale 1ns/10ps
`default_nettype none

module sbg_port_gate_props #(
    parameter int NPORT = 3,
    parameter int NPASS = 2,
    parameter int SLOTW = 7
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             sys_rst,
    // Backplane pins
    input wire logic             tck_b,
    input wire logic             trst_n_b,
    input wire logic             tdo_b,
    input wire logic             tdo_b_oe,
    input wire logic             hiz_notify_b,
    input wire logic             pass_in_b,
    input wire logic             pass_out_b,
    input wire logic [SLOTW-1:0] slot_id,
    input wire logic             lsp_oe_n,
    // Local pins
    input wire logic [NPORT-1:0] local_tck,
    input wire logic [NPORT-1:0] local_tms,
    input wire logic [NPORT-1:0] local_tdo,
    input wire logic [NPORT-1:0] local_trst_n,
    input wire logic [NPORT-1:0] local_scan_port_oe,
    input wire logic [NPORT-1:0] hiz_notify,
    input wire logic [NPORT-1:0] port_activity_enable,
    input wire logic [NPASS-1:0] local_pass_in,
    input wire logic [NPASS-1:0] local_pass_out,
    // Controller ties and internal outputs
    input wire logic [NPORT-1:0] port_selected,
    input wire logic [NPORT-1:0] port_unparked,
    input wire logic             own_tdo,
    input wire logic [SLOTW-1:0] slot_addr,
    input wire logic             logic_clear,
    input wire logic             tck_rise,
    input wire logic             tck_fall
);
    logic [2:0] up_reg;
    logic [2:0] up_next;
    logic       up_ok;

    // Cycles since either reset; pin synchronisers need a flush first
    always_comb begin
        up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
        if (sys_rst || !trst_n_b) up_next = 3'h0;
    end
    always_ff @(posedge clk) begin
        up_reg <= up_next;
    end
    assign up_ok = (up_reg == 3'h7);

    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    a_hiz_backplane: assert property (hiz_notify_b == !tdo_b_oe)
        else $error("backplane notify does not mirror its drive enable");
    a_hiz_local: assert property (hiz_notify == ~local_scan_port_oe)
        else $error("local notify does not mirror port enable");
    a_oe_float: assert property ((up_ok && lsp_oe_n)[*4] |-> local_scan_port_oe == '0)
        else $error("local port driven while output enable is high");
    a_pass_fwd: assert property ((up_ok && port_selected == NPORT'(1) && $stable(pass_in_b))[*4]
        |-> local_pass_out[0] == pass_in_b)
        else $error("pass input not routed to the selected port");
    a_pass_back: assert property ((up_ok && port_selected == NPORT'(2)
        && $stable(local_pass_in[1]))[*4] |-> pass_out_b == local_pass_in[1])
        else $error("selected port pass input not routed back");
    a_pass_idle: assert property ((up_ok && port_selected[1:0] inside {2'b00, 2'b11})[*2]
        |-> pass_out_b && local_pass_out == '1)
        else $error("pass path open without a single port 0 or 1");
    a_trst_gate: assert property (!trst_n_b |-> local_trst_n == '0)
        else $error("local test reset not low with backplane reset");
    a_trst_clear: assert property (!trst_n_b [*3] |-> logic_clear)
        else $error("internal clear missing under test reset");
    a_tck_copy: assert property (
        (up_ok && $stable(tck_b))[*4] |-> local_tck == {NPORT{tck_b}})
        else $error("local clock does not follow backplane clock");
    a_tck_rise: assert property (up_ok && $rose(tck_b) |-> ##2 (tck_rise && !tck_fall))
        else $error("test clock rise not flagged two cycles later");
    a_tck_fall: assert property (up_ok && $fell(tck_b) |-> ##2 (tck_fall && !tck_rise))
        else $error("test clock fall not flagged two cycles later");
    a_slot_addr: assert property ((up_ok && $stable(slot_id))[*4] |-> slot_addr == slot_id)
        else $error("address does not follow slot straps");
    a_activity: assert property (up_ok && $stable(port_unparked & port_selected)
        |-> port_activity_enable == (port_unparked & port_selected))
        else $error("activity enable wrong");
    a_parked_tms: assert property (
        (up_ok && !port_unparked[0])[*3] |=> $stable(local_tms[0]))
        else $error("parked port mode select moved");
    a_own_path: assert property ((up_ok && port_unparked == '0 && $stable(own_tdo))[*3]
        |-> tdo_b == own_tdo && local_tdo[0] == own_tdo)
        else $error("own register not on data output with all parked");
endmodule : sbg_port_gate_props

bind sbg_port_gate sbg_port_gate_props #(.NPORT(NPORT), .NPASS(NPASS), .SLOTW(SLOTW)) u_props (
    .clk, .sys_rst, .tck_b, .trst_n_b, .tdo_b, .tdo_b_oe, .hiz_notify_b, .pass_in_b,
    .pass_out_b, .slot_id, .lsp_oe_n, .local_tck, .local_tms, .local_tdo, .local_trst_n,
    .local_scan_port_oe, .hiz_notify, .port_activity_enable, .local_pass_in, .local_pass_out,
    .port_selected, .port_unparked, .own_tdo, .slot_addr, .logic_clear, .tck_rise, .tck_fall);

`default_nettype wire

/* test/sbg_ring_model.sv */
// Local scan ring model: one boundary cell per port
`timescale 1ns/10ps
`default_nettype none

module sbg_ring_model (
    // Local port pins as the ring sees them
    input  wire logic [2:0] tck,
    input  wire logic [2:0] tdo,
    input  wire logic [2:0] oe,
    output var  logic [2:0] tdi
);
    // Each cell shifts on its own clock rise; a floating port feeds the
    // inverse of the held bit so a stale value can never pass for data
    for (genvar i = 0; i < 3; i++) begin : g_cell
        initial tdi[i] = 1'b1;
        always @(posedge tck[i]) begin
            tdi[i] <= oe[i] ? tdo[i] : ~tdi[i];
        end
    end
endmodule : sbg_ring_model

`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the scan bridge port gating block
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic       clk = 1'b0, sys_rst = 1'b1, tck_b = 1'b0, tms_b = 1'b1, tdi_b = 1'b1;
    logic       trst_n_b = 1'b1, pass_in_b = 1'b1, lsp_oe_n = 1'b1, own_tdo = 1'b1;
    logic       tdo_b_drive = 1'b0, tck_run = 1'b0;
    logic [6:0] slot_id = 7'h00;
    logic [2:0] port_selected = 3'h0, port_unparked = 3'h0;
    logic [1:0] local_pass_in = 2'h3, local_pass_out;
    logic [2:0] local_tck, local_tms, local_tdo, local_tdi, local_trst_n, lsp_oe, hiz, act;
    logic       tdo_b, tdo_b_oe, hiz_notify_b, pass_out_b, scan_in, logic_clear, scan_mode;
    logic [6:0] slot_addr;
    int         miscompares = 0;
    int         checked = 0;

    // System clock, and a link clock that only runs inside frames
    always #25 clk = ~clk;
    // Link clock moves at the same offset as every other input, every 4 cycles
    initial begin
        forever begin
            repeat (4) @(posedge clk);
            if (tck_run) begin
                #2;
                tck_b = ~tck_b;
            end
        end
    end

    sbg_port_gate u_sbg_port_gate (
        .clk, .sys_rst, .tck_b, .tms_b, .tdi_b, .trst_n_b, .tdo_b, .tdo_b_oe, .hiz_notify_b,
        .pass_in_b, .pass_out_b, .slot_id, .lsp_oe_n, .local_tck, .local_tms, .local_tdo,
        .local_tdi, .local_trst_n, .local_scan_port_oe(lsp_oe), .hiz_notify(hiz),
        .port_activity_enable(act), .local_pass_in, .local_pass_out, .port_selected,
        .port_unparked, .own_tdo, .tdo_b_drive, .tck_rise(), .tck_fall(), .scan_in,
        .scan_mode, .slot_addr, .logic_clear);
    sbg_ring_model u_sbg_ring_model (.tck(local_tck), .tdo(local_tdo), .oe(lsp_oe),
        .tdi(local_tdi));

    // Inputs always change the same short delay after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    task automatic cmp(input logic [6:0] got, input logic [6:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp

    task automatic print_verdict;
        $display("Counts: checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    task automatic t_oe;
        lsp_oe_n = 1'b0;
        step(4);
        cmp(7'({lsp_oe, hiz}), 7'h38, "ports driven");
        lsp_oe_n = 1'b1;
        step(4);
        cmp(7'({lsp_oe, hiz}), 7'h07, "ports floating");
        lsp_oe_n = 1'b0;
        tdo_b_drive = 1'b1;
        step(4);
        cmp(7'({tdo_b_oe, hiz_notify_b}), 7'h2, "backplane driven");
        tdo_b_drive = 1'b0;
        step(2);
        cmp(7'({tdo_b_oe, hiz_notify_b}), 7'h1, "backplane floating");
    endtask : t_oe

    task automatic t_pass;
        logic [2:0] sel [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
        logic [2:0] expv [4] = '{3'h6, 3'h1, 3'h7, 3'h7};
        pass_in_b = 1'b0;
        local_pass_in = 2'b01;
        foreach (sel[i]) begin
            port_selected = sel[i];
            step(4);
            cmp(7'({pass_out_b, local_pass_out}), 7'(expv[i]), "pass path");
        end
    endtask : t_pass

    task automatic t_tck;
        tdi_b = 1'b0;
        tck_run = 1'b1;
        step(20);
        cmp(7'(scan_in), 7'h0, "scan input");
        for (int k = 0; k < 2; k++) begin
            tck_run = 1'b1;
            step(4);
            tck_run = 1'b0;
            step(5);
            cmp(7'(local_tck), 7'({3{tck_b}}), "local clocks");
        end
    endtask : t_tck

    task automatic t_chain;
        port_selected = 3'h1;
        own_tdo = 1'b0;
        step(4);
        cmp(7'({tdo_b, local_tdo[0]}), 7'h0, "own register out");
        port_unparked = 3'h1;
        tms_b = 1'b0;
        tck_run = 1'b1;
        step(40);
        cmp(7'({tdo_b, act, local_tms[0]}), 7'b0_001_0, "ring inserted");
        cmp(7'({scan_mode, local_tms, local_tdo}), 7'h30, "inserted pins");
        port_unparked = 3'h0;
        tms_b = 1'b1;
        own_tdo = 1'b1;
        step(40);
        cmp(7'({local_tms[0], act, tdo_b}), 7'h01, "ring parked");
        cmp(7'({scan_mode, local_tms, local_tdo}), 7'h77, "parked pins");
        tck_run = 1'b0;
        slot_id = 7'h5a;
        step(4);
        cmp(slot_addr, 7'h5a, "slot address");
    endtask : t_chain

    task automatic t_trst;
        trst_n_b = 1'b0;
        #1;
        cmp(7'(local_trst_n), 7'h0, "local reset follows pin");
        step(4);
        cmp(7'({logic_clear, lsp_oe, act}), 7'h40, "logic cleared");
        trst_n_b = 1'b1;
        step(8);
        cmp(7'({local_trst_n, lsp_oe}), 7'h3f, "reset released");
    endtask : t_trst

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("FAIL %0t run did not finish", $time);
        print_verdict();
    end

    initial begin
        step(10);
        sys_rst = 1'b0;
        step(4);
        t_oe();
        t_pass();
        t_tck();
        t_chain();
        t_trst();
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
